// [test/vemc_host_model.sv]
// Two-wire serial host model for the mode register port
`timescale 1ns/10ps
module vemc_host_model (
	input wire clk,
	input wire sda_oe,
	output logic scl,
	output wire sda
);
	localparam int H = 8;
	logic pull_low = 1'b0;
	// Open drain with pull-up: low while either side pulls
	assign sda = ~(pull_low | sda_oe);
	initial scl = 1'b1;
	task hp;
		repeat (H) @(posedge clk);
	endtask
	// Data bits only move while the clock is low, one half period clear of edges; start and stop move data with the clock high
	task start;
	begin
		hp;
		pull_low <= 1'b0;
		hp;
		scl <= 1'b1;
		hp;
		pull_low <= 1'b1;
		hp;
		scl <= 1'b0;
	end
	endtask
	task stop;
	begin
		hp;
		pull_low <= 1'b1;
		hp;
		scl <= 1'b1;
		hp;
		pull_low <= 1'b0;
		hp;
	end
	endtask
	task clk_bit(input logic b, output logic r);
	begin
		hp;
		pull_low <= ~b;
		hp;
		scl <= 1'b1;
		hp;
		r = sda;
		scl <= 1'b0;
	end
	endtask
	// Ninth slot is always released: device ack on writes, host nack on reads
	task xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic r;
	begin
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(d[i], r);
			q[i] = r;
		end
		clk_bit(1'b1, r);
		ack = ~r;
	end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] sub, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k1, k2, k3;
	begin
		if (sub == 8'h02 || sub == 8'h04)
			d[7] = 1'b0;
		start;
		xbyte(a, q, k1);
		xbyte(sub, q, k2);
		xbyte(d, q, k3);
		stop;
		ok = k1 & k2 & k3;
	end
	endtask
	// Address byte assumes the default device address
	task rd(input logic [7:0] sub, output logic [7:0] q, output logic ok);
		logic k1, k2, k3, n;
	begin
		start;
		xbyte(8'h54, q, k1);
		xbyte(sub, q, k2);
		start;
		xbyte(8'h55, q, k3);
		xbyte(8'hff, q, n);
		stop;
		ok = k1 & k2 & k3;
	end
	endtask
endmodule // vemc_host_model

// [test/vemc_mode_control_monitor.sv]
// Port-level assertions for the mode register bank
`timescale 1ns/10ps
module vemc_mode_control_monitor (
	input wire clk,
	input wire srst,
	input wire pal_mode,
	input wire master_mode,
	input wire slave_mode0,
	input wire blank_input_control,
	input wire [7:0] pixel_in,
	input wire [7:0] pixel_out,
	input wire interlace_active,
	input wire color_bar_active,
	input wire master_timing_active,
	input wire square_pixel_active,
	input wire subcarrier_reset_pulse,
	input wire [9:0] active_pixel_count,
	input wire [6:0] dac_current_pct,
	input wire vbi_pass_active,
	input wire [2:0] dac_b_source,
	input wire [3:0] dac_power_down,
	input wire teletext_insert_active,
	input wire teletext_request_out,
	input wire [2:0] vsync_half_lines,
	input wire sleep_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_bar;
		color_bar_active |-> master_timing_active;
	endproperty
	a_bar: assert property (p_bar) else $error("bars without master timing");
	property p_sq;
		square_pixel_active |-> !$past(master_mode) && !color_bar_active;
	endproperty
	a_sq: assert property (p_sq) else $error("square pixel in master timing");
	property p_vbi;
		vbi_pass_active |-> !$past(slave_mode0) && !$past(blank_input_control);
	endproperty
	a_vbi: assert property (p_vbi) else $error("vbi pass not allowed");
	property p_pct;
		dac_current_pct == 7'h64 || dac_current_pct == 7'h37;
	endproperty
	a_pct: assert property (p_pct) else $error("bad dac current");
	property p_pix;
		active_pixel_count == 10'h2d0 ||
			active_pixel_count == ($past(pal_mode) ? 10'h2be : 10'h2c6);
	endproperty
	a_pix: assert property (p_pix) else $error("bad active pixel count");
	property p_black;
		!$past(srst) |-> pixel_out == $past(pixel_in) ||
			($past(pixel_in) == 8'h00 && pixel_out == 8'h10);
	endproperty
	a_black: assert property (p_black) else $error("bad pixel output");
	property p_sleep;
		sleep_active |-> dac_power_down == 4'hf;
	endproperty
	a_sleep: assert property (p_sleep) else $error("dac powered in sleep");
	property p_ttx;
		teletext_request_out |-> teletext_insert_active;
	endproperty
	a_ttx: assert property (p_ttx) else $error("request without teletext");
	property p_il;
		interlace_active |-> dac_b_source == 3'h0;
	endproperty
	a_il: assert property (p_il) else $error("interlace outside composite");
	property p_vs;
		vsync_half_lines == 3'h0 || vsync_half_lines == ($past(pal_mode) ? 3'h5 : 3'h6);
	endproperty
	a_vs: assert property (p_vs) else $error("bad vsync length");
	property p_scr;
		subcarrier_reset_pulse |=> !subcarrier_reset_pulse;
	endproperty
	a_scr: assert property (p_scr) else $error("reset pulse too long");
	c_bar: cover property (color_bar_active);
	c_sleep: cover property (sleep_active);
	c_scr: cover property (subcarrier_reset_pulse);
	c_vbi: cover property (vbi_pass_active);
endmodule // vemc_mode_control_monitor
bind vemc_mode_control vemc_mode_control_monitor u_mon (.clk, .srst, .pal_mode, .master_mode,
	.slave_mode0, .blank_input_control, .pixel_in, .pixel_out, .interlace_active,
	.color_bar_active, .master_timing_active, .square_pixel_active, .subcarrier_reset_pulse,
	.active_pixel_count, .dac_current_pct, .vbi_pass_active, .dac_b_source, .dac_power_down,
	.teletext_insert_active, .teletext_request_out, .vsync_half_lines, .sleep_active);

// [test/vemc_mode_control_tb.sv]
// Self-checking bench for the mode register bank
`timescale 1ns/10ps
`include "vemc_consts.vh"
module vemc_mode_control_tb;
	logic clk = 1'b0, srst = 1'b1, pal_mode = 1'b0, master_mode = 1'b0, slave_mode0 = 1'b0;
	logic blank_input_control = 1'b0, teletext_bit_slot = 1'b0;
	logic subcarrier_reset_rtc_pin = 1'b0, teletext_data_in = 1'b0;
	logic [7:0] pixel_in = 8'h55;
	wire scl_in, sda_in, sda_out, sda_oe, interlace_active, caption_odd_enable;
	wire caption_even_enable, color_bar_active, master_timing_active, square_pixel_active;
	wire subcarrier_reset_pulse, rtc_input_level, chroma_gate, burst_gate, vbi_pass_active;
	wire teletext_insert_active, teletext_bit, teletext_request_out, rgb_sync_insert;
	wire setup_level_enable, blanking_filter_enable, sleep_active;
	wire [7:0] pixel_out;
	wire [6:0] bar_setup_tenths_ire, dac_current_pct;
	wire [9:0] active_pixel_count;
	wire [2:0] dac_a_source, dac_b_source, dac_c_source, dac_d_source, vsync_half_lines;
	wire [3:0] dac_power_down;
	int err_count = 0, n_checks = 0;
	logic ok, seen;
	logic [7:0] q;
	vemc_mode_control u_dut (.clk, .srst, .scl_in, .sda_in, .sda_out, .sda_oe, .pal_mode,
		.master_mode, .slave_mode0, .blank_input_control, .teletext_bit_slot,
		.subcarrier_reset_rtc_pin, .teletext_data_in, .pixel_in, .pixel_out, .interlace_active,
		.caption_odd_enable, .caption_even_enable, .color_bar_active, .bar_setup_tenths_ire,
		.master_timing_active, .square_pixel_active, .subcarrier_reset_pulse, .rtc_input_level,
		.active_pixel_count, .chroma_gate, .burst_gate, .dac_current_pct, .vbi_pass_active,
		.dac_a_source, .dac_b_source, .dac_c_source, .dac_d_source, .dac_power_down,
		.teletext_insert_active, .teletext_bit, .teletext_request_out, .rgb_sync_insert,
		.vsync_half_lines, .setup_level_enable, .blanking_filter_enable, .sleep_active);
	vemc_host_model u_host (.clk, .sda_oe, .scl(scl_in), .sda(sda_in));
	initial
		forever #4 clk = ~clk;
	task test_done;
	begin
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
	begin
		n_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	end
	endtask
	// Lets updates land, then samples between edges
	task w(input int n);
	begin
		repeat (n) @(posedge clk);
		@(negedge clk);
	end
	endtask
	task wrc(input logic [7:0] sub, input logic [7:0] d);
	begin
		u_host.wr(8'h54, sub, d, ok);
		chk("write ack", ok, 1'b1);
		w(2);
	end
	endtask
	task rdc(input logic [7:0] sub, input logic [7:0] e);
	begin
		u_host.rd(sub, q, ok);
		chk("read ack", ok, 1'b1);
		chk("read data", q, e);
		w(1);
	end
	endtask
	task dacs(input logic [11:0] e);
		chk("dac map", {dac_a_source, dac_b_source, dac_c_source, dac_d_source}, e);
	endtask
	initial
	begin
		#400000;
		err_count++;
		test_done;
	end
	initial
	begin
		w(1);
		@(posedge clk) srst <= 1'b0;
		w(4);
		rdc(8'h01, 8'h00);
		rdc(8'h02, 8'h00);
		rdc(8'h03, 8'h00);
		rdc(8'h04, 8'h10);
		rdc(8'h05, 8'h00);
		dacs({`VEMC_SRC_CVBS, `VEMC_SRC_CVBS, `VEMC_SRC_C, `VEMC_SRC_Y});
		chk("pct", dac_current_pct, 7'h64);
		chk("sda out", sda_out, 1'b0);
		chk("setup", setup_level_enable, 1'b1);
		wrc(8'h01, 8'h87);
		chk("bars", {color_bar_active, master_timing_active, bar_setup_tenths_ire}, 9'h1cb);
		chk("scan", {interlace_active, caption_odd_enable, caption_even_enable}, 3'h7);
		wrc(8'h01, 8'h03);
		chk("odd", {caption_odd_enable, caption_even_enable, master_timing_active}, 3'h4);
		wrc(8'h02, 8'h79);
		chk("sq", square_pixel_active, 1'b1);
		chk("line", active_pixel_count, `VEMC_PIX_470_NTSC);
		chk("gates", {chroma_gate, burst_gate, dac_current_pct}, 9'h1b7);
		@(posedge clk);
		master_mode <= 1'b1;
		pal_mode <= 1'b1;
		w(3);
		chk("sq master", square_pixel_active, 1'b0);
		chk("line pal", active_pixel_count, `VEMC_PIX_470_PAL);
		chk("bar pal", bar_setup_tenths_ire, 7'h00);
		@(posedge clk) master_mode <= 1'b0;
		wrc(8'h03, 8'hff);
		rdc(8'h03, 8'hfc);
		dacs({`VEMC_SRC_Y, `VEMC_SRC_CVBS, `VEMC_SRC_C, `VEMC_SRC_C});
		chk("vbi", vbi_pass_active, 1'b1);
		@(posedge clk);
		teletext_bit_slot <= 1'b1;
		teletext_data_in <= 1'b1;
		pixel_in <= 8'h00;
		blank_input_control <= 1'b1;
		w(3);
		chk("ttx req", teletext_request_out, 1'b1);
		chk("black", pixel_out, `VEMC_BLACK_CODE);
		chk("vbi blank", vbi_pass_active, 1'b0);
		chk("ttx bit in", teletext_bit, 1'b1);
		@(posedge clk);
		teletext_bit_slot <= 1'b0;
		blank_input_control <= 1'b0;
		slave_mode0 <= 1'b1;
		w(3);
		chk("ttx bit", teletext_request_out, 1'b0);
		chk("vbi slave0", vbi_pass_active, 1'b0);
		wrc(8'h03, 8'hbc);
		chk("ttx cont", teletext_request_out, 1'b1);
		wrc(8'h04, 8'h7b);
		dacs({`VEMC_SRC_Y, `VEMC_SRC_U, `VEMC_SRC_V, `VEMC_SRC_C});
		chk("comp", {interlace_active, rgb_sync_insert, vsync_half_lines, setup_level_enable,
			blanking_filter_enable}, 7'h15);
		chk("sleep", {sleep_active, dac_power_down}, 5'h1f);
		rdc(8'h04, 8'h7b);
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		w(4);
		chk("wake", {sleep_active, teletext_bit}, 2'h0);
		wrc(8'h04, 8'h05);
		dacs({`VEMC_SRC_CVBS, `VEMC_SRC_B, `VEMC_SRC_R, `VEMC_SRC_G});
		chk("rgb sync", rgb_sync_insert, 1'b1);
		wrc(8'h01, 8'h08);
		chk("dac c off", dac_power_down, 4'h2);
		wrc(8'h01, 8'h30);
		chk("dac b d off", dac_power_down, 4'h5);
		wrc(8'h01, 8'h60);
		chk("dac a b off", dac_power_down, 4'hc);
		wrc(8'h02, 8'h02);
		@(posedge clk) subcarrier_reset_rtc_pin <= 1'b1;
		seen = 1'b0;
		for (int i = 0; i < 10; i++)
		begin
			w(0);
			seen = seen | subcarrier_reset_pulse;
			@(posedge clk);
		end
		chk("sc reset", seen, 1'b1);
		wrc(8'h02, 8'h06);
		chk("rtc", {rtc_input_level, subcarrier_reset_pulse}, 2'h2);
		u_host.wr(8'h56, 8'h01, 8'h80, ok);
		chk("wrong addr", ok, 1'b0);
		chk("no bars", color_bar_active, 1'b0);
		test_done;
	end
endmodule // vemc_mode_control_tb

// [verilog/vemc_consts.vh]
// Constants for the video encoder mode control bank
`ifndef VEMC_CONSTS_VH
`define VEMC_CONSTS_VH
// Subaddresses of the mode registers
`define VEMC_ADDR_SCAN_CAPTION 8'h01
`define VEMC_ADDR_VIDEO_FORMAT 8'h02
`define VEMC_ADDR_VBI_TTX_OUT 8'h03
`define VEMC_ADDR_OUT_SYNC_PWR 8'h04
// Reset values
`define VEMC_RST_SCAN_CAPTION 8'h00
`define VEMC_RST_VIDEO_FORMAT 8'h00
`define VEMC_RST_VBI_TTX_OUT 8'h00
`define VEMC_RST_OUT_SYNC_PWR 8'h10
`define VEMC_RST_VBI_TTX_UPPER 6'h00
// Synchroniser reset at idle pin levels, SCL and SDA high, so no false edge
`define VEMC_PIN_IDLE 4'h3
// Field positions, scan_caption_dac_control
`define VEMC_INTERLACE 0
`define VEMC_CAPTION_LO 1
`define VEMC_DAC_PD_LO 3
`define VEMC_COLOR_BAR 7
// Field positions, video_format_control
`define VEMC_SQUARE_PIXEL 0
`define VEMC_GENLOCK_PIN 1
`define VEMC_GENLOCK_TYPE 2
`define VEMC_LINE_LENGTH 3
`define VEMC_CHROMA_GATE 4
`define VEMC_BURST_GATE 5
`define VEMC_LOW_POWER 6
// Field positions, vbi_teletext_output_config
`define VEMC_VBI_PASS 2
`define VEMC_SCART 3
`define VEMC_FOURTH_CHROMA 4
`define VEMC_TTX_ENABLE 5
`define VEMC_TTX_STYLE 6
`define VEMC_ZERO_BLACK 7
// Field positions, output_sync_power_config
`define VEMC_COMPONENT 0
`define VEMC_YUV 1
`define VEMC_RGB_SYNC 2
`define VEMC_LONG_VSYNC 3
`define VEMC_SETUP_LEVEL 4
`define VEMC_BLANK_FILTER 5
`define VEMC_SLEEP 6
// Caption field choices
`define VEMC_CC_ODD 2'h1
`define VEMC_CC_EVEN 2'h2
`define VEMC_CC_BOTH 2'h3
// DAC source codes
`define VEMC_SRC_CVBS 3'h0
`define VEMC_SRC_Y 3'h1
`define VEMC_SRC_C 3'h2
`define VEMC_SRC_R 3'h3
`define VEMC_SRC_G 3'h4
`define VEMC_SRC_B 3'h5
`define VEMC_SRC_U 3'h6
`define VEMC_SRC_V 3'h7
// Active pixel counts
`define VEMC_PIX_601 10'h2d0
`define VEMC_PIX_470_NTSC 10'h2c6
`define VEMC_PIX_470_PAL 10'h2be
// Colour bar black setup in tenths of IRE
`define VEMC_BAR_SETUP_NTSC 7'h4b
`define VEMC_BAR_SETUP_PAL 7'h00
// DAC current in percent of full
`define VEMC_DAC_FULL_PCT 7'h64
`define VEMC_DAC_LOW_PCT 7'h37
// Long vertical sync in half lines
`define VEMC_VS_HALF_NTSC 3'h6
`define VEMC_VS_HALF_PAL 3'h5
// Black code forced for all-zero pixels
`define VEMC_BLACK_CODE 8'h10
`endif

// [verilog/vemc_mode_control.v]
// Mode register bank with two-wire serial slave and decoded video controls
`timescale 1ns/10ps
`include "vemc_consts.vh"
module vemc_mode_control #(
	parameter [6:0] DEVICE_ADDRESS = 7'h2a, // Arbitrary bus address
	parameter [1:0] REVISION = 2'h0 // Arbitrary revision code
) (
	input wire clk,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire pal_mode,
	input wire master_mode,
	input wire slave_mode0,
	input wire blank_input_control,
	input wire teletext_bit_slot,
	input wire subcarrier_reset_rtc_pin,
	input wire teletext_data_in,
	input wire [7:0] pixel_in,
	output reg [7:0] pixel_out,
	output reg interlace_active,
	output reg caption_odd_enable,
	output reg caption_even_enable,
	output reg color_bar_active,
	output reg [6:0] bar_setup_tenths_ire,
	output reg master_timing_active,
	output reg square_pixel_active,
	output reg subcarrier_reset_pulse,
	output reg rtc_input_level,
	output reg [9:0] active_pixel_count,
	output reg chroma_gate,
	output reg burst_gate,
	output reg [6:0] dac_current_pct,
	output reg vbi_pass_active,
	output reg [2:0] dac_a_source,
	output reg [2:0] dac_b_source,
	output reg [2:0] dac_c_source,
	output reg [2:0] dac_d_source,
	output reg [3:0] dac_power_down,
	output reg teletext_insert_active,
	output reg teletext_bit,
	output reg teletext_request_out,
	output reg rgb_sync_insert,
	output reg [2:0] vsync_half_lines,
	output reg setup_level_enable,
	output reg blanking_filter_enable,
	output reg sleep_active
);
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_ADDR_ACK = 4'h2;
	localparam [3:0] ST_SUB = 4'h3;
	localparam [3:0] ST_SUB_ACK = 4'h4;
	localparam [3:0] ST_WR = 4'h5;
	localparam [3:0] ST_WR_ACK = 4'h6;
	localparam [3:0] ST_RD = 4'h7;
	localparam [3:0] ST_RD_ACK = 4'h8;

	reg [7:0] scan_caption_dac_control, video_format_control, output_sync_power_config;
	reg [5:0] vbi_ttx_upper;
	wire [7:0] vbi_teletext_output_config;

	// Pin synchronisers: stage one feeds stage two only
	reg [3:0] sync1;
	reg [3:0] sync2;
	reg scl_prev, sda_prev, genlock_prev;
	wire scl_s, sda_s, genlock_s, ttx_s;
	wire scl_rise, scl_fall, start_cond, stop_cond;

	reg [3:0] state;
	reg [3:0] bit_count;
	reg [7:0] shift_in;
	reg [7:0] shift_out;
	reg [7:0] pointer;
	reg read_dir, master_ack;
	reg [7:0] read_value;

	wire [7:0] rx_byte;
	wire comp, yuv, scart, fourth_chroma;
	reg [2:0] next_comp_or_chroma, next_luma_like, next_b_src, next_c_src;

	assign scl_s = sync2[0];
	assign sda_s = sync2[1];
	assign genlock_s = sync2[2];
	assign ttx_s = sync2[3];
	assign scl_rise = scl_s & ~scl_prev;
	assign scl_fall = ~scl_s & scl_prev;
	assign start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
	assign stop_cond = scl_s & scl_prev & ~sda_prev & sda_s;
	assign rx_byte = shift_in;
	assign vbi_teletext_output_config = {vbi_ttx_upper, REVISION};
	assign comp = output_sync_power_config[`VEMC_COMPONENT];
	assign yuv = output_sync_power_config[`VEMC_YUV];
	assign scart = vbi_teletext_output_config[`VEMC_SCART];
	assign fourth_chroma = vbi_teletext_output_config[`VEMC_FOURTH_CHROMA];

	always @(posedge clk)
	begin
		if (srst)
		begin
			sync1 <= `VEMC_PIN_IDLE;
			sync2 <= `VEMC_PIN_IDLE;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			genlock_prev <= 1'b0;
		end
		else
		begin
			sync1 <= {teletext_data_in, subcarrier_reset_rtc_pin, sda_in, scl_in};
			sync2 <= sync1;
			scl_prev <= scl_s;
			sda_prev <= sda_s;
			genlock_prev <= genlock_s;
		end
	end

	always @*
	begin
		case (pointer)
			`VEMC_ADDR_SCAN_CAPTION: read_value = scan_caption_dac_control;
			`VEMC_ADDR_VIDEO_FORMAT: read_value = video_format_control;
			`VEMC_ADDR_VBI_TTX_OUT: read_value = vbi_teletext_output_config;
			`VEMC_ADDR_OUT_SYNC_PWR: read_value = output_sync_power_config;
			default: read_value = 8'h00;
		endcase
	end

	// Serial slave; registers stay reachable while sleeping
	always @(posedge clk)
	begin
		if (srst)
		begin
			state <= ST_IDLE;
			bit_count <= 4'h0;
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			pointer <= 8'h00;
			read_dir <= 1'b0;
			master_ack <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			scan_caption_dac_control <= `VEMC_RST_SCAN_CAPTION;
			video_format_control <= `VEMC_RST_VIDEO_FORMAT;
			vbi_ttx_upper <= `VEMC_RST_VBI_TTX_UPPER;
			output_sync_power_config <= `VEMC_RST_OUT_SYNC_PWR;
		end
		else if (start_cond)
		begin
			state <= ST_ADDR;
			bit_count <= 4'h0;
			sda_oe <= 1'b0;
		end
		else if (stop_cond)
		begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
		end
		else if (scl_rise)
		begin
			case (state)
				ST_ADDR, ST_SUB, ST_WR:
				begin
					shift_in <= {shift_in[6:0], sda_s};
					bit_count <= bit_count + 4'h1;
				end
				ST_RD: bit_count <= bit_count + 4'h1;
				ST_RD_ACK: master_ack <= ~sda_s;
				default: bit_count <= bit_count;
			endcase
		end
		else if (scl_fall)
		begin
			case (state)
				ST_ADDR:
				if (bit_count == 4'h8)
				begin
					if (rx_byte[7:1] == DEVICE_ADDRESS)
					begin
						state <= ST_ADDR_ACK;
						read_dir <= rx_byte[0];
						sda_oe <= 1'b1;
					end
					else
						state <= ST_IDLE;
				end
				ST_ADDR_ACK:
				begin
					bit_count <= 4'h0;
					if (read_dir)
					begin
						state <= ST_RD;
						shift_out <= read_value;
						sda_oe <= ~read_value[7];
					end
					else
					begin
						state <= ST_SUB;
						sda_oe <= 1'b0;
					end
				end
				ST_SUB:
				if (bit_count == 4'h8)
				begin
					pointer <= rx_byte;
					state <= ST_SUB_ACK;
					sda_oe <= 1'b1;
				end
				ST_SUB_ACK, ST_WR_ACK:
				begin
					state <= ST_WR;
					bit_count <= 4'h0;
					sda_oe <= 1'b0;
				end
				ST_WR:
				if (bit_count == 4'h8)
				begin
					case (pointer)
						`VEMC_ADDR_SCAN_CAPTION: scan_caption_dac_control <= rx_byte;
						`VEMC_ADDR_VIDEO_FORMAT: video_format_control <= rx_byte;
						`VEMC_ADDR_VBI_TTX_OUT: vbi_ttx_upper <= rx_byte[7:2];
						`VEMC_ADDR_OUT_SYNC_PWR: output_sync_power_config <= rx_byte;
						default: pointer <= pointer;
					endcase
					pointer <= pointer + 8'h01;
					state <= ST_WR_ACK;
					sda_oe <= 1'b1;
				end
				ST_RD:
				if (bit_count == 4'h8)
				begin
					state <= ST_RD_ACK;
					pointer <= pointer + 8'h01;
					sda_oe <= 1'b0;
				end
				else
				begin
					shift_out <= {shift_out[6:0], 1'b0};
					sda_oe <= ~shift_out[6];
				end
				ST_RD_ACK:
				if (master_ack)
				begin
					state <= ST_RD;
					bit_count <= 4'h0;
					shift_out <= read_value;
					sda_oe <= ~read_value[7];
				end
				else
					state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// DAC routing from the output configuration bits
	always @*
	begin
		next_comp_or_chroma = fourth_chroma ? `VEMC_SRC_C : `VEMC_SRC_CVBS;
		next_luma_like = (comp & ~yuv) ? `VEMC_SRC_G : `VEMC_SRC_Y;
		next_b_src = comp ? (yuv ? `VEMC_SRC_U : `VEMC_SRC_B) : `VEMC_SRC_CVBS;
		next_c_src = comp ? (yuv ? `VEMC_SRC_V : `VEMC_SRC_R) : `VEMC_SRC_C;
	end

	always @(posedge clk)
	begin
		if (srst)
		begin
			pixel_out <= 8'h00;
			interlace_active <= 1'b0;
			caption_odd_enable <= 1'b0;
			caption_even_enable <= 1'b0;
			color_bar_active <= 1'b0;
			bar_setup_tenths_ire <= 7'h00;
			master_timing_active <= 1'b0;
			square_pixel_active <= 1'b0;
			subcarrier_reset_pulse <= 1'b0;
			rtc_input_level <= 1'b0;
			active_pixel_count <= `VEMC_PIX_601;
			chroma_gate <= 1'b0;
			burst_gate <= 1'b0;
			dac_current_pct <= `VEMC_DAC_FULL_PCT;
			vbi_pass_active <= 1'b0;
			dac_a_source <= `VEMC_SRC_CVBS;
			dac_b_source <= `VEMC_SRC_CVBS;
			dac_c_source <= `VEMC_SRC_C;
			dac_d_source <= `VEMC_SRC_Y;
			dac_power_down <= 4'h0;
			teletext_insert_active <= 1'b0;
			teletext_bit <= 1'b0;
			teletext_request_out <= 1'b0;
			rgb_sync_insert <= 1'b0;
			vsync_half_lines <= 3'h0;
			setup_level_enable <= 1'b0;
			blanking_filter_enable <= 1'b0;
			sleep_active <= 1'b0;
		end
		else
		begin
			// Zero input may be an undriven bus, so black is safer
			if (vbi_teletext_output_config[`VEMC_ZERO_BLACK] && pixel_in == 8'h00)
				pixel_out <= `VEMC_BLACK_CODE;
			else
				pixel_out <= pixel_in;
			interlace_active <= scan_caption_dac_control[`VEMC_INTERLACE] & ~comp;
			caption_odd_enable <= scan_caption_dac_control[`VEMC_CAPTION_LO];
			caption_even_enable <= scan_caption_dac_control[`VEMC_CAPTION_LO + 1];
			color_bar_active <= scan_caption_dac_control[`VEMC_COLOR_BAR];
			bar_setup_tenths_ire <= pal_mode ? `VEMC_BAR_SETUP_PAL : `VEMC_BAR_SETUP_NTSC;
			master_timing_active <= master_mode | scan_caption_dac_control[`VEMC_COLOR_BAR];
			// Colour bars imply master, so they also block square pixel
			square_pixel_active <= video_format_control[`VEMC_SQUARE_PIXEL] & ~master_mode
				& ~scan_caption_dac_control[`VEMC_COLOR_BAR];
			subcarrier_reset_pulse <= video_format_control[`VEMC_GENLOCK_PIN]
				& ~video_format_control[`VEMC_GENLOCK_TYPE] & genlock_s & ~genlock_prev;
			rtc_input_level <= video_format_control[`VEMC_GENLOCK_PIN]
				& video_format_control[`VEMC_GENLOCK_TYPE] & genlock_s;
			if (!video_format_control[`VEMC_LINE_LENGTH])
				active_pixel_count <= `VEMC_PIX_601;
			else
				active_pixel_count <= pal_mode ? `VEMC_PIX_470_PAL : `VEMC_PIX_470_NTSC;
			chroma_gate <= video_format_control[`VEMC_CHROMA_GATE];
			burst_gate <= video_format_control[`VEMC_BURST_GATE];
			dac_current_pct <= video_format_control[`VEMC_LOW_POWER] ?
				`VEMC_DAC_LOW_PCT : `VEMC_DAC_FULL_PCT;
			vbi_pass_active <= vbi_teletext_output_config[`VEMC_VBI_PASS] & ~slave_mode0
				& ~blank_input_control;
			dac_a_source <= scart ? next_luma_like : next_comp_or_chroma;
			dac_b_source <= next_b_src;
			dac_c_source <= next_c_src;
			dac_d_source <= scart ? next_comp_or_chroma : next_luma_like;
			// Stored order is C, D, B, A; output order is A, B, C, D
			dac_power_down <= {scan_caption_dac_control[`VEMC_DAC_PD_LO + 3],
				scan_caption_dac_control[`VEMC_DAC_PD_LO + 2],
				scan_caption_dac_control[`VEMC_DAC_PD_LO],
				scan_caption_dac_control[`VEMC_DAC_PD_LO + 1]} |
				{4{output_sync_power_config[`VEMC_SLEEP]}};
			teletext_insert_active <= vbi_teletext_output_config[`VEMC_TTX_ENABLE];
			teletext_bit <= vbi_teletext_output_config[`VEMC_TTX_ENABLE] & ttx_s;
			teletext_request_out <= vbi_teletext_output_config[`VEMC_TTX_ENABLE] &
				(~vbi_teletext_output_config[`VEMC_TTX_STYLE] | teletext_bit_slot);
			rgb_sync_insert <= output_sync_power_config[`VEMC_RGB_SYNC];
			if (output_sync_power_config[`VEMC_LONG_VSYNC])
				vsync_half_lines <= pal_mode ? `VEMC_VS_HALF_PAL : `VEMC_VS_HALF_NTSC;
			else
				vsync_half_lines <= 3'h0;
			setup_level_enable <= output_sync_power_config[`VEMC_SETUP_LEVEL] & ~pal_mode;
			blanking_filter_enable <= output_sync_power_config[`VEMC_BLANK_FILTER];
			sleep_active <= output_sync_power_config[`VEMC_SLEEP];
		end
	end
endmodule // vemc_mode_control
